// ### core/sec_pkg.sv
// constants shared by both ends of the three-wire serial word memory link
// assumes a 25 MHz system clock at each end; the link clock comes from the host
package sec_pkg;
	localparam int CLK_MHZ = 25;
	// programming interval, longest time in microseconds
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// least time select stays low between frames, in nanoseconds
	localparam int SELECT_LOW_TIME_NS = 200;
	localparam int SELECT_LOW_CYCLES = (SELECT_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
	// host waits this long after raising select before trusting the status line
	localparam logic [3:0] STATUS_SETTLE = 4'h8;
	// bits taken after the start bit when each field is complete
	localparam logic [4:0] OP_END = 5'h02;
	localparam logic [4:0] ADDR_END = 5'h0A;
	localparam logic [4:0] DATA_END = 5'h1A;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	// clocks per command, start bit included
	localparam logic [4:0] SHORT_CLOCKS = 5'h0B;
	localparam logic [4:0] LONG_CLOCKS = 5'h1B;
	// zeros the host sends ahead of the start bit
	localparam logic [4:0] LEAD_ZEROS = 5'h02;
	// host rise numbers that carry read data bits
	localparam logic [4:0] RD_FIRST_RISE = 5'h0E;
	localparam logic [4:0] RD_LAST_RISE = 5'h1D;
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	// sub-codes in the top two address bits of the extended opcode
	localparam logic [1:0] SUB_PROGRAM_LOCK = 2'h0;
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_WRITE_ENABLE = 2'h3;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam int WORDS = 256;

	typedef enum logic [2:0] {
		SEC_IDLE = 3'b000,
		SEC_LEAD = 3'b001,
		SEC_SHIFT = 3'b010,
		SEC_GAP = 3'b011,
		SEC_STATUS = 3'b100,
		SEC_DONE = 3'b101
	} sec_host_state_t;

	function automatic logic sec_is_long(input logic [1:0] op, input logic [1:0] sub);
		sec_is_long = (op == OP_WRITE) || (op == OP_READ) || (op == OP_EXT && sub == SUB_WRITE_ALL);
	endfunction : sec_is_long

	function automatic logic sec_is_prog(input logic [1:0] op, input logic [1:0] sub);
		sec_is_prog = (op == OP_WRITE) || (op == OP_ERASE)
			|| (op == OP_EXT && (sub == SUB_WRITE_ALL || sub == SUB_ERASE_ALL));
	endfunction : sec_is_prog
endpackage : sec_pkg

// ### core/sec_link_if.sv
// the three wires plus the shared serial output between host and memory
// assumes a pull-down on the serial output: it reads low while nobody drives it
interface sec_link_if;
	logic select;
	logic shift_clock;
	logic serial_in;
	logic so_out;
	logic so_oe_n;
	logic so_line;

	assign so_line = !so_oe_n & so_out;

	modport dev (
		input select,
		input shift_clock,
		input serial_in,
		output so_out,
		output so_oe_n
	);

	modport host (
		output select,
		output shift_clock,
		output serial_in,
		input so_line
	);
endinterface : sec_link_if

// ### core/sec_dev.sv
// memory end: command shifter on shift_clock, programming timer on clk
// assumes shift_clock only runs while select is high and the host keeps its rules
// Summary of operation
// - zeros before first one ignored; one starts
// - start, opcode, address, data; MSB first
// - write-disabled after reset until enable command
// - programming begins on select fall after last bit
// - select low before last data bit aborts
// - after last data bit rise, no cancel
// - extra clock then select low cancels
// - launched programming always completes, no abort
// - continuous clocking past the last bit cancels
// - erase commands uncancellable after last address bit; sec_dev still cancels them on an extra clock
// - host drops select only while clock low
// - output floats except read data or status
// - start bit during ready drops status, floats
// - select high after programming shows status
// - busy low, self-timed, other commands refused
// - ready high after at most 5 ms
// - host holds serial input low while busy
// - busy commands discarded, ready commands accepted
// - read drives dummy zero with last address
// - next start bit floats the status output
// - tied lines: clock low or start within 4
module sec_dev #(
	parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// link
	sec_link_if.dev link,
	// observation
	output logic busy,
	output logic write_enabled
);
	logic [15:0] mem [sec_pkg::WORDS];

	// link domain
	logic sel_rst_n;
	logic started;
	logic [4:0] cnt;
	logic [1:0] op_sh;
	logic [7:0] addr_sh;
	logic [15:0] data_sh;
	logic busy_s1;
	logic busy_s2;
	logic start_tgl;
	logic done_tgl;
	logic extra_tgl;
	logic [1:0] cmd_op;
	logic [7:0] cmd_addr;
	logic [15:0] cmd_data;
	logic rd_en;
	logic rd_q;
	logic [15:0] rd_sh;
	logic [7:0] rd_addr;
	logic [3:0] rd_bit;
	logic [7:0] full_addr;
	logic [1:0] sub_now;
	logic is_long;
	logic is_prog;
	logic start_now;

	// system domain
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic sel_fall;
	logic start_ev;
	logic done_ev;
	logic extra_ev;
	logic pending;
	logic launch;
	logic launch_prog;
	logic status_mode;
	logic [16:0] timer;
	logic [1:0] cmd_sub;

	// parser is cleared whenever select is low
	assign sel_rst_n = arst_n & link.select;
	assign full_addr = {addr_sh[6:0], link.serial_in};
	assign sub_now = (cnt == sec_pkg::ADDR_END - 5'h01) ? addr_sh[6:5] : addr_sh[7:6];
	assign is_long = sec_pkg::sec_is_long(op_sh, sub_now);
	assign is_prog = sec_pkg::sec_is_prog(op_sh, sub_now) || op_sh == sec_pkg::OP_EXT;
	assign start_now = !started && link.serial_in && !busy_s2;

	always_ff @(posedge link.shift_clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
		end
		else
		begin
			busy_s1 <= busy;
			busy_s2 <= busy_s1;
		end
	end

	always_ff @(posedge link.shift_clock or negedge sel_rst_n)
	begin
		if (!sel_rst_n)
		begin
			started <= 1'b0;
			cnt <= 5'h00;
			op_sh <= 2'h0;
			addr_sh <= 8'h00;
			data_sh <= 16'h0000;
		end
		else if (!started)
		begin
			// busy refuses the start bit, so the whole command is dropped
			if (start_now)
			begin
				started <= 1'b1;
			end
		end
		else
		begin
			if (cnt != sec_pkg::CNT_MAX)
			begin
				cnt <= cnt + 5'h01;
			end
			if (cnt < sec_pkg::OP_END)
			begin
				op_sh <= {op_sh[0], link.serial_in};
			end
			else if (cnt < sec_pkg::ADDR_END)
			begin
				addr_sh <= full_addr;
			end
			else if (cnt < sec_pkg::DATA_END)
			begin
				data_sh <= {data_sh[14:0], link.serial_in};
			end
		end
	end

	// events survive select going low; they are seen by the system domain
	always_ff @(posedge link.shift_clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			start_tgl <= 1'b0;
			done_tgl <= 1'b0;
			extra_tgl <= 1'b0;
			cmd_op <= 2'h0;
			cmd_addr <= 8'h00;
			cmd_data <= 16'h0000;
		end
		else if (!link.select)
		begin
			cmd_op <= cmd_op;
		end
		else if (start_now)
		begin
			start_tgl <= !start_tgl;
		end
		else if (started && cnt >= sec_pkg::OP_END && is_prog)
		begin
			if (!is_long && cnt == sec_pkg::ADDR_END - 5'h01)
			begin
				done_tgl <= !done_tgl;
				cmd_op <= op_sh;
				cmd_addr <= full_addr;
			end
			else if (is_long && cnt == sec_pkg::DATA_END - 5'h01)
			begin
				done_tgl <= !done_tgl;
				cmd_op <= op_sh;
				cmd_addr <= addr_sh;
				cmd_data <= {data_sh[14:0], link.serial_in};
			end
			else if ((!is_long && cnt == sec_pkg::ADDR_END)
				|| (is_long && cnt == sec_pkg::DATA_END))
			begin
				extra_tgl <= !extra_tgl;
			end
		end
	end

	// read path with auto increment
	always_ff @(posedge link.shift_clock or negedge sel_rst_n)
	begin
		if (!sel_rst_n)
		begin
			rd_en <= 1'b0;
			rd_q <= 1'b0;
			rd_sh <= 16'h0000;
			rd_addr <= 8'h00;
			rd_bit <= 4'h0;
		end
		else if (started && op_sh == sec_pkg::OP_READ && cnt >= sec_pkg::OP_END)
		begin
			if (cnt == sec_pkg::ADDR_END - 5'h01)
			begin
				rd_en <= 1'b1;
				rd_q <= 1'b0;
				rd_addr <= full_addr;
				rd_sh <= mem[full_addr];
				rd_bit <= 4'h0;
			end
			else if (rd_en)
			begin
				rd_q <= rd_sh[15];
				rd_bit <= rd_bit + 4'h1;
				if (rd_bit == 4'hF)
				begin
					rd_addr <= rd_addr + 8'h01;
					rd_sh <= mem[rd_addr + 8'h01];
				end
				else
				begin
					rd_sh <= {rd_sh[14:0], 1'b0};
				end
			end
		end
	end

	// select and event toggles into the system domain
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
		end
		else
		begin
			sync1 <= {link.select, start_tgl, done_tgl, extra_tgl};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign sel_fall = sync3[3] && !sync2[3];
	assign start_ev = sync3[2] ^ sync2[2];
	assign done_ev = sync3[1] ^ sync2[1];
	assign extra_ev = sync3[0] ^ sync2[0];
	assign cmd_sub = cmd_addr[7:6];
	// abort before the last bit leaves pending clear: nothing changes
	assign launch = sel_fall && pending && !busy;
	assign launch_prog = launch && write_enabled
		&& sec_pkg::sec_is_prog(cmd_op, cmd_sub);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pending <= 1'b0;
		end
		else if (done_ev)
		begin
			pending <= 1'b1;
		end
		else if (extra_ev || start_ev || launch)
		begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			write_enabled <= 1'b0;
		end
		else if (launch && cmd_op == sec_pkg::OP_EXT)
		begin
			if (cmd_sub == sec_pkg::SUB_WRITE_ENABLE)
			begin
				write_enabled <= 1'b1;
			end
			else if (cmd_sub == sec_pkg::SUB_PROGRAM_LOCK)
			begin
				write_enabled <= 1'b0;
			end
		end
	end

	// self-timed interval; select plays no part once started
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy <= 1'b0;
			timer <= 17'h00000;
		end
		else if (launch_prog)
		begin
			busy <= 1'b1;
			timer <= 17'(PROG_CYCLES - 1);
		end
		else if (busy)
		begin
			if (timer == 17'h00000)
			begin
				busy <= 1'b0;
			end
			else
			begin
				timer <= timer - 17'h00001;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (launch_prog)
		begin
			for (int i = 0; i < sec_pkg::WORDS; i++)
			begin
				if (cmd_op == sec_pkg::OP_WRITE && cmd_addr == 8'(i))
				begin
					mem[i] <= cmd_data;
				end
				else if (cmd_op == sec_pkg::OP_ERASE && cmd_addr == 8'(i))
				begin
					mem[i] <= sec_pkg::ERASED_WORD;
				end
				else if (cmd_op == sec_pkg::OP_EXT && cmd_sub == sec_pkg::SUB_WRITE_ALL)
				begin
					mem[i] <= cmd_data;
				end
				else if (cmd_op == sec_pkg::OP_EXT && cmd_sub == sec_pkg::SUB_ERASE_ALL)
				begin
					mem[i] <= sec_pkg::ERASED_WORD;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			status_mode <= 1'b0;
		end
		else if (launch_prog)
		begin
			status_mode <= 1'b1;
		end
		else if (start_ev)
		begin
			status_mode <= 1'b0;
		end
	end

	// started gates the status at once, before the system domain sees it
	// raw select also gates it, so the line floats as soon as select drops
	assign link.so_oe_n = !((status_mode && link.select && sync2[3] && !started) || rd_en);
	assign link.so_out = rd_en ? rd_q : !busy;
endmodule : sec_dev

// ### core/sec_host.sv
// host end: frames commands, makes shift_clock by dividing clk, polls status
// assumes the memory end on the other side of sec_link_if
module sec_host #(
	parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// link
	sec_link_if.host link,
	// command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_addr,
	input wire logic [15:0] cmd_data,
	input wire logic [4:0] cmd_abort_clocks,
	input wire logic cmd_extra,
	// answer
	output logic rsp_valid,
	output logic rsp_ok,
	output logic [15:0] rsp_data
);
	sec_pkg::sec_host_state_t state;
	logic [28:0] tx;
	logic [4:0] nclk;
	logic [4:0] rcnt;
	logic [1:0] phase;
	logic [17:0] wait_cnt;
	logic is_read;
	logic is_prog;
	logic aborted;
	logic so_s1;
	logic so_s2;

	assign cmd_ready = state == sec_pkg::SEC_IDLE;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			so_s1 <= 1'b0;
			so_s2 <= 1'b0;
		end
		else
		begin
			so_s1 <= link.so_line;
			so_s2 <= so_s1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= sec_pkg::SEC_IDLE;
			link.select <= 1'b0;
			link.shift_clock <= 1'b0;
			link.serial_in <= 1'b0;
			tx <= 29'h00000000;
			nclk <= 5'h00;
			rcnt <= 5'h00;
			phase <= 2'h0;
			wait_cnt <= 18'h00000;
			is_read <= 1'b0;
			is_prog <= 1'b0;
			aborted <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_ok <= 1'b0;
			rsp_data <= 16'h0000;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state)
				sec_pkg::SEC_IDLE:
				begin
					if (cmd_valid)
					begin
						tx <= {3'b001, cmd_op, cmd_addr, cmd_data};
						is_read <= cmd_op == sec_pkg::OP_READ;
						is_prog <= sec_pkg::sec_is_prog(cmd_op, cmd_addr[7:6]);
						aborted <= cmd_abort_clocks != 5'h00 || cmd_extra;
						if (cmd_abort_clocks != 5'h00)
						begin
							nclk <= cmd_abort_clocks;
						end
						else
						begin
							nclk <= sec_pkg::LEAD_ZEROS + 5'(cmd_extra)
								+ (sec_pkg::sec_is_long(cmd_op, cmd_addr[7:6])
								? sec_pkg::LONG_CLOCKS : sec_pkg::SHORT_CLOCKS);
						end
						wait_cnt <= 18'h00000;
						state <= sec_pkg::SEC_LEAD;
					end
				end
				sec_pkg::SEC_LEAD:
				begin
					wait_cnt <= wait_cnt + 18'h00001;
					if (wait_cnt == 18'(sec_pkg::SELECT_LOW_CYCLES))
					begin
						link.select <= 1'b1;
						link.serial_in <= tx[28];
						tx <= {tx[27:0], 1'b0};
						rcnt <= 5'h00;
						phase <= 2'h0;
						state <= sec_pkg::SEC_SHIFT;
					end
				end
				sec_pkg::SEC_SHIFT:
				begin
					phase <= phase + 2'h1;
					if (phase == 2'h0)
					begin
						link.shift_clock <= 1'b1;
						rcnt <= rcnt + 5'h01;
					end
					else if (phase == 2'h2)
					begin
						link.shift_clock <= 1'b0;
						link.serial_in <= tx[28];
						tx <= {tx[27:0], 1'b0};
					end
					else if (phase == 2'h3)
					begin
						if (is_read && rcnt >= sec_pkg::RD_FIRST_RISE
							&& rcnt <= sec_pkg::RD_LAST_RISE)
						begin
							rsp_data <= {rsp_data[14:0], so_s2};
						end
						if (rcnt == nclk)
						begin
							link.select <= 1'b0;
							link.serial_in <= 1'b0;
							wait_cnt <= 18'h00000;
							state <= sec_pkg::SEC_GAP;
						end
					end
				end
				sec_pkg::SEC_GAP:
				begin
					wait_cnt <= wait_cnt + 18'h00001;
					if (wait_cnt == 18'(sec_pkg::SELECT_LOW_CYCLES))
					begin
						wait_cnt <= 18'h00000;
						if (is_prog && !aborted)
						begin
							link.select <= 1'b1;
							state <= sec_pkg::SEC_STATUS;
						end
						else
						begin
							rsp_ok <= !aborted;
							state <= sec_pkg::SEC_DONE;
						end
					end
				end
				sec_pkg::SEC_STATUS:
				begin
					// clock and data stay low while the status is up
					wait_cnt <= wait_cnt + 18'h00001;
					if (wait_cnt >= 18'(sec_pkg::STATUS_SETTLE) && so_s2)
					begin
						link.select <= 1'b0;
						rsp_ok <= 1'b1;
						state <= sec_pkg::SEC_DONE;
					end
					else if (wait_cnt == 18'(PROG_CYCLES + 64))
					begin
						link.select <= 1'b0;
						rsp_ok <= 1'b0;
						state <= sec_pkg::SEC_DONE;
					end
				end
				sec_pkg::SEC_DONE:
				begin
					rsp_valid <= 1'b1;
					state <= sec_pkg::SEC_IDLE;
				end
				default:
				begin
					state <= sec_pkg::SEC_IDLE;
				end
			endcase
		end
	end
endmodule : sec_host

// ### sim/sec_link_chk.sv
// checker on the link wires and the memory's busy and enable flags
// assumes all signals sampled on clk; both ends share arst_n
module sec_link_chk #(
	parameter int PROG_CYCLES = 200
) (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// link
	input wire logic select,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic so_out,
	input wire logic so_oe_n,
	// memory state
	input wire logic busy,
	input wire logic write_enabled
);
	timeunit 1ns;
	timeprecision 1ps;

	int busy_cnt;

	// length of the current busy interval
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_cnt <= 0;
		else
			busy_cnt <= busy ? busy_cnt + 1 : 0;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	a_float_unselected: assert property (!select && !$past(select) |-> so_oe_n)
		else $error("serial output driven while unselected");
	a_busy_shows_low: assert property ($past(busy, 3) && busy && !so_oe_n |-> !so_out)
		else $error("status not low while busy");
	a_status_driven: assert property ((busy && select) [*4] |-> !so_oe_n)
		else $error("status not driven while selected and busy");
	a_prog_length: assert property ($fell(busy) |->
		busy_cnt >= PROG_CYCLES - 2 && busy_cnt <= PROG_CYCLES + 2)
		else $error("programming interval length wrong");
	a_busy_bounded: assert property (busy_cnt <= PROG_CYCLES + 2)
		else $error("programming interval never ends");
	a_launch_enabled: assert property ($rose(busy) |-> $past(write_enabled) && !select)
		else $error("programming launched without enable or select fall");
	a_enable_at_gap: assert property ($changed(write_enabled) |-> !select)
		else $error("enable state changed inside a frame");
	a_busy_keeps_we: assert property (busy && $past(busy) |-> $stable(write_enabled))
		else $error("command accepted while busy");
	a_select_clock_low: assert property ($fell(select) |-> !shift_clock && !$past(shift_clock))
		else $error("select dropped near a clock rise");
	a_quiet_input: assert property (busy && select |-> !serial_in)
		else $error("serial input high while polling busy status");

	c_launch: cover property ($rose(busy));
	c_enable: cover property ($rose(write_enabled));
	c_read_out: cover property (select && !so_oe_n && !busy);
endmodule : sec_link_chk

// ### sim/serial_eeprom_cancel_status_bench.sv
// self-checking bench: host end and memory end joined by the link interface
// assumes PROG_CYCLES shortened to 200 at both ends
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module serial_eeprom_cancel_status_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PROG = 200;

	typedef struct packed {
		logic [1:0] op;
		logic [7:0] addr;
		logic [15:0] data;
		logic [4:0] ab;
		logic ex;
		logic [1:0] ok;
		logic [15:0] rd;
		logic we;
	} sec_row_t;

	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	logic [1:0] cmd_op = 2'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [15:0] cmd_data = 16'h0000;
	logic [4:0] cmd_abort_clocks = 5'h00;
	logic cmd_extra = 1'b0;
	logic rsp_valid;
	logic rsp_ok;
	logic [15:0] rsp_data;
	logic busy;
	logic write_enabled;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	sec_row_t rows[$];

	sec_link_if sec_link_if_inst ();

	sec_dev #(.PROG_CYCLES(PROG)) sec_dev_inst (.clk(clk), .arst_n(arst_n),
		.link(sec_link_if_inst.dev), .busy(busy), .write_enabled(write_enabled));

	sec_host #(.PROG_CYCLES(PROG)) sec_host_inst (.clk(clk), .arst_n(arst_n),
		.link(sec_link_if_inst.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_abort_clocks(cmd_abort_clocks), .cmd_extra(cmd_extra),
		.rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data));

	sec_link_chk #(.PROG_CYCLES(PROG)) sec_link_chk_inst (.clk(clk), .arst_n(arst_n),
		.select(sec_link_if_inst.select), .shift_clock(sec_link_if_inst.shift_clock),
		.serial_in(sec_link_if_inst.serial_in), .so_out(sec_link_if_inst.so_out),
		.so_oe_n(sec_link_if_inst.so_oe_n), .busy(busy), .write_enabled(write_enabled));

	always #20 clk = ~clk;

	task automatic print_verdict();
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	function automatic sec_row_t mk(input logic [1:0] op, input logic [7:0] addr,
		input logic [15:0] data, input logic [4:0] ab, input logic ex, input logic [1:0] ok,
		input logic [15:0] rd, input logic we);
		mk = '{op, addr, data, ab, ex, ok, rd, we};
	endfunction : mk

	// ok field: 0 or 1 expected, 2 not compared
	task automatic run(input sec_row_t r);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		cmd_op = r.op;
		cmd_addr = r.addr;
		cmd_data = r.data;
		cmd_abort_clocks = r.ab;
		cmd_extra = r.ex;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(rsp_valid, 1'b1)
		if (r.ok != 2'h2) `CHK(rsp_ok, r.ok[0])
		if (r.op == sec_pkg::OP_READ) `CHK(rsp_data, r.rd)
		repeat (8) @(posedge clk);
		// an aborted frame may still have launched programming: let it finish
		while (busy === 1'b1 && n < 2000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(busy, 1'b0)
		`CHK(write_enabled, r.we)
	endtask : run

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		rows.push_back(mk(2'h1, 8'h10, 16'hA5C3, 5'h00, 1'b0, 2'h0, 16'h0000, 1'b0));
		rows.push_back(mk(2'h0, 8'hC0, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		rows.push_back(mk(2'h1, 8'h10, 16'hA5C3, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		rows.push_back(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hA5C3, 1'b1));
		rows.push_back(mk(2'h3, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		rows.push_back(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b1));
		rows.push_back(mk(2'h0, 8'h40, 16'h1234, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		rows.push_back(mk(2'h2, 8'h33, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h1234, 1'b1));
		rows.push_back(mk(2'h0, 8'h80, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		rows.push_back(mk(2'h2, 8'h33, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b1));
		rows.push_back(mk(2'h0, 8'h00, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b0));
		rows.push_back(mk(2'h0, 8'hC0, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h0000, 1'b1));
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		`CHK(sec_link_if_inst.so_line, 1'b0)
		`CHK(write_enabled, 1'b0)
		foreach (rows[i])
			run(rows[i]);
		// write dropped one rise before the last data bit
		run(mk(2'h1, 8'h10, 16'h5555, 5'h1C, 1'b0, 2'h0, 16'h0000, 1'b1));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b1));
		// extra rise after a full write frame
		run(mk(2'h1, 8'h10, 16'h6666, 5'h00, 1'b1, 2'h0, 16'h0000, 1'b1));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b1));
		// dropped right after the last data bit rise
		run(mk(2'h1, 8'h10, 16'h7777, 5'h1D, 1'b0, 2'h2, 16'h0000, 1'b1));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h7777, 1'b1));
		// erase dropped before and after the last address bit
		run(mk(2'h3, 8'h10, 16'h0000, 5'h0C, 1'b0, 2'h0, 16'h0000, 1'b1));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'h7777, 1'b1));
		run(mk(2'h3, 8'h10, 16'h0000, 5'h0D, 1'b0, 2'h2, 16'h0000, 1'b1));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b1));
		// reset mid-run falls back to write-disabled
		@(posedge clk);
		#1;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		`CHK(write_enabled, 1'b0)
		`CHK(sec_link_if_inst.so_line, 1'b0)
		#1;
		arst_n = 1'b1;
		run(mk(2'h1, 8'h10, 16'h2222, 5'h00, 1'b0, 2'h0, 16'h0000, 1'b0));
		run(mk(2'h2, 8'h10, 16'h0000, 5'h00, 1'b0, 2'h1, 16'hFFFF, 1'b0));
		print_verdict();
	end
endmodule : serial_eeprom_cancel_status_bench
